// ===== core/rtia_pkg.sv
// Package of constants and carriers for the clock indirect access gateway
//
// Overview of operation
// - Lock status reads 0x00 when locked, 0x01 after first key 0xA5.
// - Status reads 0x02 when unlocked, 0x03 when disabled until reset.
// - Writing 0xA5 then 0xF1 to lock register unlocks the interface.
// - Awaiting second key, any value other than 0xF1 disables until reset.
// - While unlocked, any lock register write re-locks the interface.
// - While disabled, lock register writes are ignored.
// - Address bit 7 shows transfer busy; writing 1 starts an indirect read.
// - Address bit 6 enables autoread.
// - Address bit 5 reads zero, writes ignored.
// - Address bit 4 selects the short access strobe.
// - Address bits 3:0 select the internal register targeted.
// - Address auto-increments after access to snapshot or compare bytes.
// - With autoread, each data register read while idle launches the next indirect read.
// - Indirect access takes 7 cycles, or 6 with short strobe.
// - Internal 0x00-0x03 are snapshot bytes, 0x08-0x0B compare bytes.
// - A data register write starts an indirect write of that byte.
package rtia_pkg;

  // Register bus addresses
  localparam logic [7:0] ADDR_REG_OFS = 8'hac;
  localparam logic [7:0] DATA_REG_OFS = 8'had;
  localparam logic [7:0] KEY_REG_OFS  = 8'hae;

  // Key codes and status encodings
  localparam logic [7:0] KEY_FIRST      = 8'ha5;
  localparam logic [7:0] KEY_SECOND     = 8'hf1;
  localparam logic [7:0] ST_LOCKED      = 8'h00;
  localparam logic [7:0] ST_WAIT_SECOND = 8'h01;
  localparam logic [7:0] ST_OPEN        = 8'h02;
  localparam logic [7:0] ST_DISABLED    = 8'h03;

  // Address register field positions
  localparam int BUSY_BIT  = 7;
  localparam int AUTO_BIT  = 6;
  localparam int SHORT_BIT = 4;

  // Reset values
  localparam logic [7:0] ADDR_REG_RST = 8'h00;
  localparam logic [7:0] DATA_REG_RST = 8'h00;

  // Internal map: snapshot and compare byte groups
  localparam logic [3:0] SNAP_BASE = 4'h0;
  localparam logic [3:0] SNAP_LAST = 4'h3;
  localparam logic [3:0] CMP_BASE  = 4'h8;
  localparam logic [3:0] CMP_LAST  = 4'hb;

  // Access timing in system clocks
  localparam logic [2:0] ACC_CYC_NORMAL = 3'h7;
  localparam logic [2:0] ACC_CYC_SHORT  = 3'h6;

  // Register bus request from the core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtia_sfr_req_s;

  // Access toward the internal register file
  typedef struct packed {
    logic       we;
    logic       re;
    logic [3:0] addr;
    logic [7:0] wdata;
  } rtia_int_req_s;

  typedef enum logic [1:0] {
    LK_LOCKED,
    LK_WAIT,
    LK_OPEN,
    LK_DISABLED
  } rtia_lock_e;

endpackage

// ===== core/rtia_regfile.sv
// Internal clock register file of sixteen bytes, registered read data
`timescale 1ns/100ps
module rtia_regfile
  import rtia_pkg::*;
#(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic          sys_clk_i,
  input  wire logic          srst_i,
  // Access port
  input  wire rtia_int_req_s req_i,
  output logic [7:0]         rdata_o
);
  import rtia_pkg::*;

  logic [7:0] mem_q [DEPTH];
  logic [7:0] mem_d [DEPTH];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Next values of storage and read data
  always_comb begin
    mem_d   = mem_q;
    rdata_d = rdata_q;
    if (req_i.we) begin
      mem_d[req_i.addr] = req_i.wdata;
    end
    if (req_i.re) begin
      rdata_d = mem_q[req_i.addr];
    end
  end

  // Registers
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rdata_q <= 8'h00;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else begin
      rdata_q <= rdata_d;
      mem_q   <= mem_d;
    end
  end

  assign rdata_o = rdata_q;
endmodule

// ===== core/rtia_gateway.sv
// Lock-and-key gateway and indirect access engine for the clock registers
`timescale 1ns/100ps
module rtia_gateway (
  // Clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    srst_i,
  // Special function register bus
  input  wire rtia_pkg::rtia_sfr_req_s sfr_req_i,
  output logic [7:0]                   sfr_rdata_o,
  // Status
  output logic                         iface_open_o,
  output logic                         busy_o
);
  import rtia_pkg::*;

  // Lock machine state and its status code
  rtia_lock_e    lock_q;
  rtia_lock_e    lock_d;
  logic [7:0]    lock_code;

  // Address register fields
  logic          auto_q;
  logic          auto_d;
  logic          short_q;
  logic          short_d;
  logic [3:0]    addr_q;
  logic [3:0]    addr_d;

  // Data register and access engine
  logic [7:0]    data_q;
  logic [7:0]    data_d;
  logic          busy_q;
  logic          busy_d;
  logic          is_wr_q;
  logic          is_wr_d;
  logic [2:0]    cnt_q;
  logic [2:0]    cnt_d;

  // Registered bus read data
  logic [7:0]    rdata_q;
  logic [7:0]    rdata_d;

  // Decoded bus strobes
  logic          key_wr;
  logic          adr_wr;
  logic          dat_wr;
  logic          dat_rd;
  logic          adr_rd;
  logic          key_rd;

  // Engine control strobes
  logic          snap_or_cmp;
  logic          start_rd;
  logic          start_wr;
  logic          done;

  // Internal register file port
  rtia_int_req_s int_req;
  logic [7:0]    int_rdata;

  // Bus decode, write strobes
  assign key_wr = sfr_req_i.wr && (sfr_req_i.addr == KEY_REG_OFS);
  assign adr_wr = sfr_req_i.wr && (sfr_req_i.addr == ADDR_REG_OFS);
  assign dat_wr = sfr_req_i.wr && (sfr_req_i.addr == DATA_REG_OFS);

  // Bus decode, read strobes
  assign key_rd = sfr_req_i.rd && (sfr_req_i.addr == KEY_REG_OFS);
  assign adr_rd = sfr_req_i.rd && (sfr_req_i.addr == ADDR_REG_OFS);
  assign dat_rd = sfr_req_i.rd && (sfr_req_i.addr == DATA_REG_OFS);

  // Status code of the lock machine
  always_comb begin
    case (lock_q)
      LK_LOCKED:   lock_code = ST_LOCKED;
      LK_WAIT:     lock_code = ST_WAIT_SECOND;
      LK_OPEN:     lock_code = ST_OPEN;
      LK_DISABLED: lock_code = ST_DISABLED;
      default:     lock_code = ST_DISABLED;
    endcase
  end

  // Lock machine; an address or data register access while locked also disables the interface
  always_comb begin
    lock_d = lock_q;
    case (lock_q)
      LK_LOCKED: begin
        if (key_wr) begin
          lock_d = (sfr_req_i.wdata == KEY_FIRST) ? LK_WAIT : LK_DISABLED;
        end else if (adr_wr || dat_wr || adr_rd || dat_rd) begin
          // Indirect access before unlock disables the interface
          lock_d = LK_DISABLED;
        end
      end
      LK_WAIT: begin
        if (key_wr) begin
          lock_d = (sfr_req_i.wdata == KEY_SECOND) ? LK_OPEN : LK_DISABLED;
        end else if (adr_wr || dat_wr || adr_rd || dat_rd) begin
          // Indirect access between the keys disables the interface
          lock_d = LK_DISABLED;
        end
      end
      LK_OPEN: begin
        if (key_wr) begin
          lock_d = LK_LOCKED;
        end
      end
      LK_DISABLED: lock_d = LK_DISABLED;
      default:     lock_d = LK_DISABLED;
    endcase
  end

  assign iface_open_o = (lock_q == LK_OPEN);

  // Snapshot and compare byte detection
  assign snap_or_cmp = ((addr_q >= SNAP_BASE) && (addr_q <= SNAP_LAST)) ||
                       ((addr_q >= CMP_BASE) && (addr_q <= CMP_LAST));

  // Start conditions, only while open and idle
  assign start_rd = iface_open_o && !busy_q &&
                    ((adr_wr && sfr_req_i.wdata[BUSY_BIT]) ||
                     (dat_rd && auto_q));
  assign start_wr = iface_open_o && !busy_q && dat_wr;

  // Last cycle of a running access
  assign done     = busy_q && (cnt_q == 3'h1);

  // Address register, access engine and data register
  always_comb begin
    auto_d  = auto_q;
    short_d = short_q;
    addr_d  = addr_q;
    data_d  = data_q;
    busy_d  = busy_q;
    is_wr_d = is_wr_q;
    cnt_d   = cnt_q;
    // Address register fields, only while open and idle
    if (iface_open_o && adr_wr && !busy_q) begin
      auto_d  = sfr_req_i.wdata[AUTO_BIT];
      short_d = sfr_req_i.wdata[SHORT_BIT];
      addr_d  = sfr_req_i.wdata[3:0];
    end

    // Data register takes the byte to be written
    if (start_wr) begin
      data_d = sfr_req_i.wdata;
    end

    // Load the cycle count, or step down until done
    if (start_rd || start_wr) begin
      busy_d  = 1'b1;
      is_wr_d = start_wr;
      cnt_d   = short_d ? ACC_CYC_SHORT : ACC_CYC_NORMAL;
    end else if (busy_q) begin
      cnt_d = cnt_q - 3'h1;
      if (done) begin
        busy_d = 1'b0;
        if (!is_wr_q) begin
          data_d = int_rdata;
        end
        if (snap_or_cmp) begin
          addr_d = addr_q + 4'h1;
        end
      end
    end
  end

  // Internal write on the last cycle; internal read requested one cycle earlier so its data is there on the last cycle
  always_comb begin
    int_req.we    = done && is_wr_q;
    int_req.re    = busy_q && !is_wr_q && (cnt_q == 3'h2);
    int_req.addr  = addr_q;
    int_req.wdata = data_q;
  end

  // Read data mux
  always_comb begin
    rdata_d = 8'h00;
    // Status is readable in every lock state
    if (key_rd) begin
      rdata_d = lock_code;
    end else if (adr_rd && iface_open_o) begin
      rdata_d = {busy_q, auto_q, 1'b0, short_q, addr_q};
    end else if (dat_rd && iface_open_o) begin
      rdata_d = data_q;
    end
  end

  // Registers
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      // Reset values of all state
      lock_q  <= LK_LOCKED;
      auto_q  <= ADDR_REG_RST[AUTO_BIT];
      short_q <= ADDR_REG_RST[SHORT_BIT];
      addr_q  <= ADDR_REG_RST[3:0];
      data_q  <= DATA_REG_RST;
      busy_q  <= 1'b0;
      is_wr_q <= 1'b0;
      cnt_q   <= 3'h0;
      rdata_q <= 8'h00;
    end else begin
      // Advance every register
      lock_q  <= lock_d;
      auto_q  <= auto_d;
      short_q <= short_d;
      addr_q  <= addr_d;
      data_q  <= data_d;
      busy_q  <= busy_d;
      is_wr_q <= is_wr_d;
      cnt_q   <= cnt_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from flip-flops
  assign sfr_rdata_o = rdata_q;
  assign busy_o      = busy_q;

  // Internal clock register file
  rtia_regfile #(
    .DEPTH (16)
  ) u_regfile (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .req_i     (int_req),
    .rdata_o   (int_rdata)
  );
endmodule

// ===== sim/rtia_gateway_props.sv
// Port checker of the clock register gateway
`timescale 1ns/100ps
module rtia_gateway_props
  import rtia_pkg::*;
(
  input wire logic          sys_clk_i,
  input wire logic          srst_i,
  input wire rtia_sfr_req_s sfr_req_i,
  input wire logic [7:0]    sfr_rdata_o,
  input wire logic          iface_open_o,
  input wire logic          busy_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // Decoded strobes
  wire logic wk = sfr_req_i.wr && sfr_req_i.addr == KEY_REG_OFS;
  wire logic rk = sfr_req_i.rd && sfr_req_i.addr == KEY_REG_OFS;
  wire logic ra = sfr_req_i.rd && sfr_req_i.addr == ADDR_REG_OFS && iface_open_o;
  wire logic gd = sfr_req_i.wr && sfr_req_i.addr == DATA_REG_OFS;
  wire logic ga = sfr_req_i.wr && sfr_req_i.addr == ADDR_REG_OFS && sfr_req_i.wdata[7];
  a_open_status: assert property (rk && iface_open_o |=> sfr_rdata_o == ST_OPEN)
    else $error("open status code wrong");
  a_unlock_key: assert property ($rose(iface_open_o) |-> $past(wk)
    && $past(sfr_req_i.wdata) == KEY_SECOND) else $error("opened without second key");
  a_relock_write: assert property (iface_open_o && wk |=> !iface_open_o)
    else $error("key write did not relock");
  a_unused_bit: assert property (ra |=> !sfr_rdata_o[5])
    else $error("unused bit reads one");
  a_busy_bit: assert property (ra |=> sfr_rdata_o[7] == $past(busy_o))
    else $error("busy bit differs from busy output");
  a_read_start: assert property (ga && iface_open_o && !busy_o |-> ##[1:2] busy_o)
    else $error("indirect read not started");
  a_write_start: assert property (gd && iface_open_o && !busy_o |-> ##[1:2] busy_o)
    else $error("indirect write not started");
  a_busy_len: assert property ($rose(busy_o) |-> busy_o[*6] ##[1:2] !busy_o)
    else $error("transfer length wrong");
  a_closed_idle: assert property (!iface_open_o && !busy_o |=> !busy_o)
    else $error("transfer while closed");
endmodule

bind rtia_gateway rtia_gateway_props props_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
  .sfr_req_i(sfr_req_i), .sfr_rdata_o(sfr_rdata_o), .iface_open_o(iface_open_o),
  .busy_o(busy_o));

// ===== sim/rtia_core_model.sv
// Core side model issuing register bus strobes
`timescale 1ns/100ps
module rtia_core_model (
  // Clock and read data
  input  wire logic                    sys_clk_i,
  input  wire logic [7:0]              rdata_i,
  // Request toward the gateway
  output rtia_pkg::rtia_sfr_req_s      req_o
);
  import rtia_pkg::*;
  initial req_o = '0;
  // One-cycle write strobe, released at the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk_i);
    req_o <= '0;
  endtask
  // One-cycle read strobe, data taken the cycle after
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk_i);
    req_o <= '0;
    #1;
    d = rdata_i;
  endtask
endmodule

// ===== sim/rtia_gateway_tb.sv
// Testbench of the clock register gateway
`timescale 1ns/100ps
module rtia_gateway_tb;
  import rtia_pkg::*;
  logic          sys_clk_i   = 1'b0;
  logic          srst_i      = 1'b1;
  rtia_sfr_req_s req;
  logic [7:0]    rdata;
  logic          iface_open;
  logic          busy;
  logic [7:0]    v;
  int            n;
  int            n_mismatch  = 0;
  int            check_count = 0;
  always #50 sys_clk_i = ~sys_clk_i;
  rtia_gateway dut_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .sfr_req_i(req),
    .sfr_rdata_o(rdata), .iface_open_o(iface_open), .busy_o(busy));
  rtia_core_model core_u (.sys_clk_i(sys_clk_i), .rdata_i(rdata), .req_o(req));
  // Compare and count
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    core_u.rd(a, v);
    chk("register", v, exp);
  endtask
  // Counts busy cycles over a bounded window
  task automatic bsy(input logic [7:0] exp);
    n = 0;
    #1;
    repeat (12) begin
      if (busy === 1'b1) n++;
      @(posedge sys_clk_i);
      #1;
    end
    chk("busy cycles", 8'(n), exp);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    rdc(KEY_REG_OFS, ST_LOCKED);
    core_u.wr(KEY_REG_OFS, KEY_FIRST);
    rdc(KEY_REG_OFS, ST_WAIT_SECOND);
    core_u.wr(KEY_REG_OFS, KEY_SECOND);
    rdc(KEY_REG_OFS, ST_OPEN);
    rdc(ADDR_REG_OFS, ADDR_REG_RST);
    rdc(DATA_REG_OFS, DATA_REG_RST);
    core_u.wr(ADDR_REG_OFS, 8'h28);
    rdc(ADDR_REG_OFS, 8'h08);
    core_u.wr(DATA_REG_OFS, 8'h5a);
    bsy(8'h07);
    rdc(ADDR_REG_OFS, 8'h09);
    core_u.wr(ADDR_REG_OFS, 8'h88);
    bsy(8'h07);
    rdc(DATA_REG_OFS, 8'h5a);
    core_u.wr(ADDR_REG_OFS, 8'h14);
    core_u.wr(DATA_REG_OFS, 8'h3c);
    bsy(8'h06);
    rdc(ADDR_REG_OFS, 8'h14);
    core_u.wr(ADDR_REG_OFS, 8'hd8);
    bsy(8'h06);
    rdc(DATA_REG_OFS, 8'h5a);
    bsy(8'h06);
    rdc(ADDR_REG_OFS, 8'h5a);
    rdc(DATA_REG_OFS, 8'h00);
    bsy(8'h06);
    core_u.wr(KEY_REG_OFS, 8'h00);
    rdc(KEY_REG_OFS, ST_LOCKED);
    core_u.wr(KEY_REG_OFS, KEY_FIRST);
    core_u.wr(KEY_REG_OFS, 8'h12);
    rdc(KEY_REG_OFS, ST_DISABLED);
    core_u.wr(KEY_REG_OFS, KEY_FIRST);
    core_u.wr(KEY_REG_OFS, KEY_SECOND);
    rdc(KEY_REG_OFS, ST_DISABLED);
    chk("open flag", {7'h00, iface_open}, 8'h00);
    finish_test();
  end
endmodule
